// file: mfcd_top.sv
// per-axis motor and feedback configuration decoder with apb registers
`timescale 1ns/10ps
`include "mfcd_params.svh"

module mfcd_top #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire mfcd_pkg::mfcd_apb_req_t apb_req,
  output mfcd_pkg::mfcd_apb_rsp_t apb_rsp,
  // hall sensors, three per axis
  input wire logic [3*NUM_AXES-1:0] hall_in,
  // decoded per-axis configuration
  output mfcd_pkg::mfcd_axis_cfg_t [NUM_AXES-1:0] axis_cfg,
  // interrupt
  output logic irq
);
  import mfcd_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (NUM_AXES < 1 || NUM_AXES > 4) begin : g_chk
    $error("NUM_AXES must lie in 1..4");
  end

  localparam int AW = 2;
  // the axis select register must be able to name every axis
  if ((1 << AW) < NUM_AXES) begin : g_chk_aw
    $error("AW too narrow for NUM_AXES");
  end

  // ----------------------------------------
  // storage: staged (written) and active (applied at reinit)
  // ----------------------------------------
  logic [31:0] stage_reg [NUM_AXES][`MFCD_NUM_PARAMS];
  logic [31:0] active_reg [NUM_AXES][`MFCD_NUM_PARAMS];
  logic [AW-1:0] axis_sel_reg;
  logic [4:0] param_idx_reg;
  logic [`MFCD_IRQ_W-1:0] irq_status_reg;
  logic [`MFCD_IRQ_W-1:0] irq_enable_reg;
  logic [`MFCD_IRQ_W-1:0] irq_status_next;
  logic [NUM_AXES-1:0] cfg_err;
  logic [NUM_AXES-1:0] hall_flt;
  logic [NUM_AXES-1:0] hall_flt_q;
  logic init_pulse;

  // reset value of one parameter slot
  function automatic logic [31:0] rst_val(input int ax, input int idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      `MFCD_P_PRI_CHAN: v = 32'(ax + 1);
      `MFCD_P_PRI_SETUP: v = `MFCD_RST_SETUP;
      `MFCD_P_SEC_SETUP: v = `MFCD_RST_SETUP;
      `MFCD_P_COMMUT: v = `MFCD_RST_COMMUT;
      `MFCD_P_ENC_STEPS: v = `MFCD_RST_STEPS;
      `MFCD_P_STEP_HI: v = `MFCD_RST_STEP_HI;
      `MFCD_P_STEP_LO: v = `MFCD_RST_STEP_LO;
      `MFCD_P_MICROSTEP: v = `MFCD_RST_STEPS;
      `MFCD_P_ENC_VERIFY: v = `MFCD_RST_VERIFY;
      `MFCD_P_ENC_SPEED: v = `MFCD_RST_SPEED;
      default: v = 32'h0000_0000; // drive type resets to brush
    endcase
    return v;
  endfunction : rst_val

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic idx_ok;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  // one strobe per writable register so each write branch tests a single term
  logic wr_axis_sel;
  logic wr_param_idx;
  logic wr_param_data;
  logic wr_ctrl;
  logic wr_irq_clear;
  logic wr_irq_enable;
  assign wr_axis_sel = wr_en && (apb_req.paddr == `MFCD_OFF_AXIS_SEL);
  assign wr_param_idx = wr_en && (apb_req.paddr == `MFCD_OFF_PARAM_IDX);
  assign wr_param_data = wr_en && (apb_req.paddr == `MFCD_OFF_PARAM_DATA) && idx_ok;
  assign wr_ctrl = wr_en && (apb_req.paddr == `MFCD_OFF_CTRL);
  assign wr_irq_clear = wr_en && (apb_req.paddr == `MFCD_OFF_IRQ_CLEAR);
  assign wr_irq_enable = wr_en && (apb_req.paddr == `MFCD_OFF_IRQ_ENABLE);
  assign idx_ok = (param_idx_reg < 5'(`MFCD_NUM_PARAMS)) && (int'(axis_sel_reg) < NUM_AXES);
  always_comb begin
    unique case (apb_req.paddr)
      `MFCD_OFF_AXIS_SEL, `MFCD_OFF_PARAM_IDX, `MFCD_OFF_PARAM_DATA, `MFCD_OFF_CTRL,
      `MFCD_OFF_IRQ_STATUS, `MFCD_OFF_IRQ_CLEAR, `MFCD_OFF_IRQ_ENABLE, `MFCD_OFF_DECODE,
      `MFCD_OFF_AXIS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // zero wait states; unmapped or out-of-range data access answers with pslverr
  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
      (!addr_ok || (apb_req.paddr == `MFCD_OFF_PARAM_DATA && !idx_ok));
    apb_rsp.prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (apb_req.paddr)
        `MFCD_OFF_AXIS_SEL: apb_rsp.prdata = {30'h0, axis_sel_reg};
        `MFCD_OFF_PARAM_IDX: apb_rsp.prdata = {27'h0, param_idx_reg};
        `MFCD_OFF_PARAM_DATA: apb_rsp.prdata = idx_ok ? stage_reg[axis_sel_reg][param_idx_reg] : 32'h0;
        `MFCD_OFF_IRQ_STATUS: apb_rsp.prdata = {29'h0, irq_status_reg};
        `MFCD_OFF_IRQ_ENABLE: apb_rsp.prdata = {29'h0, irq_enable_reg};
        `MFCD_OFF_DECODE: apb_rsp.prdata = (int'(axis_sel_reg) < NUM_AXES) ?
          32'(axis_cfg[axis_sel_reg]) : 32'h0;
        `MFCD_OFF_AXIS_STATUS: apb_rsp.prdata = {24'h0, 4'(hall_flt_q), 4'(cfg_err)};
        default: apb_rsp.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // index registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_sel_reg <= 2'h0;
      param_idx_reg <= 5'h00;
    end else if (wr_axis_sel) begin
      axis_sel_reg <= apb_req.pwdata[AW-1:0];
    end else if (wr_param_idx) begin
      param_idx_reg <= apb_req.pwdata[4:0];
    end
  end

  // a ctrl write with bit 0 clear is accepted and does nothing
  assign init_pulse = wr_ctrl && apb_req.pwdata[0];

  // ----------------------------------------
  // parameter storage
  // ----------------------------------------
  // writes land in the staged copy; decode sees only the active copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        for (int p = 0; p < `MFCD_NUM_PARAMS; p++) begin
          stage_reg[a][p] <= rst_val(a, p);
        end
      end
    end else if (wr_param_data) begin
      // percent fields saturate at 100 rather than overflow
      if ((param_idx_reg == `MFCD_P_STEP_HI || param_idx_reg == `MFCD_P_STEP_LO) &&
          apb_req.pwdata > `MFCD_PCT_MAX) begin
        stage_reg[axis_sel_reg][param_idx_reg] <= `MFCD_PCT_MAX;
      end else begin
        stage_reg[axis_sel_reg][param_idx_reg] <= apb_req.pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        for (int p = 0; p < `MFCD_NUM_PARAMS; p++) begin
          active_reg[a][p] <= rst_val(a, p);
        end
      end
    end else if (init_pulse) begin
      active_reg <= stage_reg;
    end
  end

  // ----------------------------------------
  // per-axis decode
  // ----------------------------------------
  mfcd_axis_cfg_t cfg_next [NUM_AXES];
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
    logic [5:0] pch;
    logic [2:0] psu;
    logic [2:0] ssu;
    logic [5:0] sch;
    logic [1:0] drv;
    logic [2:0] hall;
    assign pch = active_reg[g][`MFCD_P_PRI_CHAN][5:0];
    assign sch = active_reg[g][`MFCD_P_SEC_CHAN][5:0];
    assign psu = active_reg[g][`MFCD_P_PRI_SETUP][2:0];
    assign ssu = active_reg[g][`MFCD_P_SEC_SETUP][2:0];
    assign drv = active_reg[g][`MFCD_P_DRIVE][1:0];
    assign hall = hall_in[3*g +: 3];
    logic pri_su_bad;
    logic sec_ch_bad;
    logic sec_su_bad;
    // upper bits count too, so a huge code never aliases onto a legal one
    assign pri_su_bad = (psu > `MFCD_SETUP_MAX) || (|active_reg[g][`MFCD_P_PRI_SETUP][31:3]);
    assign sec_ch_bad = (sch > `MFCD_CH_LAS4_HI) || (|active_reg[g][`MFCD_P_SEC_CHAN][31:6]);
    assign sec_su_bad = (ssu > `MFCD_SETUP_MAX) || (|active_reg[g][`MFCD_P_SEC_SETUP][31:3]);

    always_comb begin
      logic pri_big;
      logic sec_bad;
      pri_big = |active_reg[g][`MFCD_P_PRI_CHAN][31:6];
      sec_bad = 1'b0;
      cfg_next[g] = '0;
      unique case (drv)
        2'd0: cfg_next[g].motor = MFCD_MOTOR_BRUSH;
        2'd1: cfg_next[g].motor = MFCD_MOTOR_BRUSHLESS;
        default: cfg_next[g].motor = MFCD_MOTOR_STEPPER;
      endcase
      cfg_next[g].single_cmd = (drv == 2'd0);
      // a nonzero secondary channel selects dual-loop
      cfg_next[g].dual_loop = (active_reg[g][`MFCD_P_SEC_CHAN] != 32'h0);
      cfg_next[g].pri_type = MFCD_FB_INVALID;
      if (pri_big) begin
        cfg_next[g].pri_type = MFCD_FB_INVALID;
      end else if (pch == 6'd0) begin
        // open loop only makes sense for a stepper
        cfg_next[g].pri_type = (drv[1]) ? MFCD_FB_OPEN : MFCD_FB_INVALID;
      end else if (pch <= `MFCD_CH_ENC_OPT_HI) begin
        cfg_next[g].pri_type = MFCD_FB_ENCODER;
        cfg_next[g].pri_board = (pch > `MFCD_CH_ENC_MAIN_HI);
      end else if (pch <= `MFCD_CH_RES2_HI) begin
        cfg_next[g].pri_type = MFCD_FB_RESOLVER;
        cfg_next[g].pri_board = (pch > `MFCD_CH_RES1_HI);
      end else if (pch <= `MFCD_CH_LAS4_HI) begin
        cfg_next[g].pri_type = MFCD_FB_LASER;
        cfg_next[g].laser_x512 = (pch <= `MFCD_CH_LAS512_HI);
        cfg_next[g].pri_board = cfg_next[g].laser_x512 ? (pch > `MFCD_CH_LAS512_B1_HI) :
          (pch > `MFCD_CH_LAS4_B1_HI);
      end
      unique case (psu)
        3'd1: cfg_next[g].counts_per_rev = 17'h00400;
        3'd2: cfg_next[g].counts_per_rev = 17'h01000;
        3'd3: cfg_next[g].counts_per_rev = 17'h04000;
        3'd4, 3'd5: cfg_next[g].counts_per_rev = 17'h10000;
        default: cfg_next[g].counts_per_rev = 17'h00000;
      endcase
      if (cfg_next[g].pri_type == MFCD_FB_ENCODER) begin
        cfg_next[g].home_ref = MFCD_HOME_MARKER;
      end else if (cfg_next[g].pri_type == MFCD_FB_RESOLVER) begin
        cfg_next[g].home_ref = MFCD_HOME_NULL;
      end else begin
        cfg_next[g].home_ref = MFCD_HOME_NONE;
      end
      cfg_next[g].step_hi_pct = active_reg[g][`MFCD_P_STEP_HI][6:0];
      cfg_next[g].step_lo_pct = active_reg[g][`MFCD_P_STEP_LO][6:0];
      // secondary settings are checked only in dual-loop
      sec_bad = cfg_next[g].dual_loop && (sec_ch_bad || sec_su_bad);
      cfg_err[g] = (cfg_next[g].pri_type == MFCD_FB_INVALID) || sec_bad ||
        pri_su_bad ||
        // a resolver with no resolution code cannot be served
        (cfg_next[g].pri_type == MFCD_FB_RESOLVER && psu == 3'd0);
    end
    // invalid hall state is a fault only on a brushless axis
    assign hall_flt[g] = (drv == 2'd1) && (hall == 3'b000 || hall == 3'b111);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        axis_cfg[a] <= '0;
      end
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        axis_cfg[a] <= cfg_next[a];
      end
    end
  end

  // ----------------------------------------
  // hall fault tracking
  // ----------------------------------------
  // the registered copy feeds both the status read and the rising-edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_flt_q <= '0;
    end else begin
      hall_flt_q <= hall_flt;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [`MFCD_IRQ_W-1:0] irq_clr;
  logic [`MFCD_IRQ_W-1:0] irq_set;
  logic init_q;
  assign irq_clr = wr_irq_clear ?
    apb_req.pwdata[`MFCD_IRQ_W-1:0] : '0;
  // error flag is checked one cycle after reinit, once the decode has settled
  assign irq_set[`MFCD_IRQ_INIT_DONE] = init_q;
  assign irq_set[`MFCD_IRQ_HALL_FLT] = |(hall_flt & ~hall_flt_q);
  assign irq_set[`MFCD_IRQ_CFG_ERR] = init_q && (|cfg_err);
  // status bits drop only by a software clear
  // set wins over a clear in the same cycle
  assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b0;
    end else begin
      init_q <= init_pulse;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= '0;
    end else if (wr_irq_enable) begin
      irq_enable_reg <= apb_req.pwdata[`MFCD_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);
endmodule : mfcd_top

// file: mfcd_params.svh
// constants for the motor feedback configuration decoder
`ifndef MFCD_PARAMS_SVH
`define MFCD_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MFCD_OFF_AXIS_SEL 12'h000
`define MFCD_OFF_PARAM_IDX 12'h004
`define MFCD_OFF_PARAM_DATA 12'h008
`define MFCD_OFF_CTRL 12'h00C
`define MFCD_OFF_IRQ_STATUS 12'h010
`define MFCD_OFF_IRQ_CLEAR 12'h014
`define MFCD_OFF_IRQ_ENABLE 12'h018
`define MFCD_OFF_DECODE 12'h01C
`define MFCD_OFF_AXIS_STATUS 12'h020
// ----------------------------------------
// parameter indices inside the group
// ----------------------------------------
`define MFCD_P_PRI_CHAN 5'd0
`define MFCD_P_SEC_CHAN 5'd1
`define MFCD_P_PRI_SETUP 5'd2
`define MFCD_P_SEC_SETUP 5'd3
`define MFCD_P_DRIVE 5'd4
`define MFCD_P_COMMUT 5'd5
`define MFCD_P_ENC_STEPS 5'd6
`define MFCD_P_STEP_HI 5'd8
`define MFCD_P_STEP_LO 5'd9
`define MFCD_P_MICROSTEP 5'd10
`define MFCD_P_ENC_VERIFY 5'd11
`define MFCD_P_ENC_SPEED 5'd12
`define MFCD_NUM_PARAMS 20
// ----------------------------------------
// reset values
// ----------------------------------------
`define MFCD_RST_SETUP 32'h0000_0003
`define MFCD_RST_COMMUT 32'h0000_0004
`define MFCD_RST_STEPS 32'h0000_0FA0
`define MFCD_RST_STEP_HI 32'h0000_0046
`define MFCD_RST_STEP_LO 32'h0000_0023
`define MFCD_RST_VERIFY 32'h0000_0001
`define MFCD_RST_SPEED 32'h0000_0001
`define MFCD_PCT_MAX 32'h0000_0064
// ----------------------------------------
// channel and setup code limits
// ----------------------------------------
`define MFCD_CH_ENC_MAIN_HI 6'd4
`define MFCD_CH_ENC_OPT_HI 6'd8
`define MFCD_CH_RES1_HI 6'd12
`define MFCD_CH_RES2_HI 6'd16
`define MFCD_CH_LAS512_HI 6'd20
`define MFCD_CH_LAS4_HI 6'd24
`define MFCD_CH_LAS512_B1_HI 6'd18
`define MFCD_CH_LAS4_B1_HI 6'd22
`define MFCD_SETUP_MAX 3'd5
// ----------------------------------------
// interrupt bit positions
// ----------------------------------------
`define MFCD_IRQ_CFG_ERR 0
`define MFCD_IRQ_HALL_FLT 1
`define MFCD_IRQ_INIT_DONE 2
`define MFCD_IRQ_W 3
`endif

// file: mfcd_pkg.sv
// types for the motor feedback configuration decoder
package mfcd_pkg;
  typedef enum logic [1:0] {
    MFCD_MOTOR_BRUSH = 2'b00,
    MFCD_MOTOR_BRUSHLESS = 2'b01,
    MFCD_MOTOR_STEPPER = 2'b11
  } mfcd_motor_t;
  typedef enum logic [2:0] {
    MFCD_FB_OPEN = 3'd0,
    MFCD_FB_ENCODER = 3'd1,
    MFCD_FB_RESOLVER = 3'd2,
    MFCD_FB_LASER = 3'd3,
    MFCD_FB_INVALID = 3'd7
  } mfcd_fb_t;
  typedef enum logic [1:0] {
    MFCD_HOME_NONE = 2'd0,
    MFCD_HOME_MARKER = 2'd1,
    MFCD_HOME_NULL = 2'd2
  } mfcd_home_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mfcd_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mfcd_apb_rsp_t;
  typedef struct packed {
    mfcd_motor_t motor;
    logic single_cmd;
    logic dual_loop;
    mfcd_fb_t pri_type;
    logic pri_board;
    logic laser_x512;
    logic [16:0] counts_per_rev;
    mfcd_home_t home_ref;
    logic [6:0] step_hi_pct;
    logic [6:0] step_lo_pct;
  } mfcd_axis_cfg_t;
endpackage : mfcd_pkg

// file: mfcd_top_props.sv
// assertion checker bound to the decoder top
`timescale 1ns/10ps
`include "mfcd_params.svh"
module mfcd_top_props #(
  parameter int NUM_AXES = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire mfcd_pkg::mfcd_apb_req_t apb_req,
  input wire mfcd_pkg::mfcd_apb_rsp_t apb_rsp,
  // axis side
  input wire logic [3*NUM_AXES-1:0] hall_in,
  input wire mfcd_pkg::mfcd_axis_cfg_t [NUM_AXES-1:0] axis_cfg,
  input wire logic irq
);
  import mfcd_pkg::*;
  // ------
  // helpers
  // ------
  logic [1:0] up;
  logic rein_q;
  logic [4:0] idx_q;
  logic wr;
  mfcd_axis_cfg_t c;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign c = axis_cfg[0];
  // outputs carry reset values only until the first edge after release; checks start once up reaches 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up <= 2'h0;
      rein_q <= 1'b0;
      idx_q <= 5'h00;
    end else begin
      up <= (up == 2'h2) ? up : up + 2'h1;
      rein_q <= wr & (apb_req.paddr == `MFCD_OFF_CTRL) & apb_req.pwdata[0];
      if (wr && apb_req.paddr == `MFCD_OFF_PARAM_IDX) idx_q <= apb_req.pwdata[4:0];
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_single;
    up == 2'h2 |-> c.single_cmd == (c.motor == MFCD_MOTOR_BRUSH);
  endproperty
  a_single: assert property (p_single) else $error("single command flag wrong");
  property p_marker;
    up == 2'h2 && c.pri_type == MFCD_FB_ENCODER && c.motor == MFCD_MOTOR_BRUSH
      |-> c.home_ref == MFCD_HOME_MARKER;
  endproperty
  a_marker: assert property (p_marker) else $error("encoder home not marker");
  property p_null;
    up == 2'h2 && c.pri_type == MFCD_FB_RESOLVER |-> c.home_ref == MFCD_HOME_NULL;
  endproperty
  a_null: assert property (p_null) else $error("resolver home not null");
  property p_counts;
    up == 2'h2 && c.pri_type == MFCD_FB_RESOLVER && c.counts_per_rev != 17'h0
      |-> c.counts_per_rev inside {17'h400, 17'h1000, 17'h4000, 17'h10000};
  endproperty
  a_counts: assert property (p_counts) else $error("resolver counts off");
  property p_pct;
    up == 2'h2 |-> c.step_hi_pct <= 7'h64 && c.step_lo_pct <= 7'h64;
  endproperty
  a_pct: assert property (p_pct) else $error("current percent above full");
  property p_hold;
    up == 2'h2 && !$stable(axis_cfg) |-> $past(rein_q);
  endproperty
  a_hold: assert property (p_hold) else $error("config moved without reinit");
  property p_bad_idx;
    apb_req.psel && apb_req.penable && apb_req.paddr == `MFCD_OFF_PARAM_DATA
      && idx_q >= 5'h14 |-> apb_rsp.pslverr;
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("index past group accepted");
  property p_no_wait;
    apb_req.psel && !apb_req.penable ##1 apb_req.penable |-> apb_rsp.pready;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("access not answered");
  property p_laser;
    up == 2'h2 && c.laser_x512 |-> c.pri_type == MFCD_FB_LASER;
  endproperty
  a_laser: assert property (p_laser) else $error("fine laser flag off");
endmodule : mfcd_top_props
bind mfcd_top mfcd_top_props #(.NUM_AXES(NUM_AXES)) u_props (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .hall_in(hall_in), .axis_cfg(axis_cfg), .irq(irq));

// file: mfcd_hall_model.sv
// hall sensor model feeding the decoder
`timescale 1ns/10ps
module mfcd_hall_model #(
  parameter int NUM_AXES = 4
) (
  // clock
  input wire logic pclk,
  // per-axis broken sensor select
  input wire logic [NUM_AXES-1:0] bad,
  // sensor lines
  output logic [3*NUM_AXES-1:0] hall_in
);
  // six-step codes, never all-zero or all-one
  localparam logic [17:0] SEQ = 18'h2CC99;
  logic [2:0] ph = 3'h0;
  always @(posedge pclk) ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
  // a broken sensor alternates the two illegal states
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) hall_in[3*a+:3] = bad[a] ? {3{ph[0]}} : SEQ[3*ph+:3];
  end
endmodule : mfcd_hall_model

// file: tb_top.sv
// self-checking bench for the decoder
`timescale 1ns/10ps
`include "mfcd_params.svh"
module tb_top;
  import mfcd_pkg::*;
  logic pclk;
  logic presetn;
  mfcd_apb_req_t req;
  mfcd_apb_rsp_t rsp;
  logic [11:0] hall;
  mfcd_axis_cfg_t [3:0] cfg;
  logic irq;
  logic [3:0] bad;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] rn;
  logic er;
  logic [5:0] ch;
  logic [2:0] su;
  logic [1:0] dr;
  int err_count;
  int n_tests;
  logic [4:0] di [6] = '{5'h1, 5'h3, 5'h5, 5'h6, 5'h10, 5'h13};
  logic [31:0] dv [6] = '{32'h0, 32'h3, 32'h4, 32'hFA0, 32'h0, 32'h0};
  mfcd_top #(.NUM_AXES(4)) DUT (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .hall_in(hall), .axis_cfg(cfg), .irq(irq));
  mfcd_hall_model #(.NUM_AXES(4)) u_hall (.pclk(pclk), .bad(bad), .hall_in(hall));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ------
  // helpers
  // ------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic mfcd_axis_cfg_t ex(input logic [5:0] c, input logic s,
      input logic [2:0] u, input logic [1:0] d);
    mfcd_axis_cfg_t e;
    e = '0;
    e.motor = d[1] ? MFCD_MOTOR_STEPPER : mfcd_motor_t'(d);
    e.single_cmd = (d == 2'h0);
    e.dual_loop = s;
    // open loop is legal only for a stepper drive
    e.pri_type = (c == 6'h0) ? (d[1] ? MFCD_FB_OPEN : MFCD_FB_INVALID) :
      (c < 6'h9) ? MFCD_FB_ENCODER :
      (c < 6'h11) ? MFCD_FB_RESOLVER : (c < 6'h19) ? MFCD_FB_LASER : MFCD_FB_INVALID;
    e.pri_board = c inside {[5:8], [13:16], 19, 20, 23, 24};
    e.laser_x512 = c inside {[17:20]};
    e.counts_per_rev = (u == 3'h0 || u > 3'h5) ? 17'h0 : (u > 3'h3) ? 17'h10000 :
      17'h1 << (2 * u + 8);
    e.home_ref = (e.pri_type == MFCD_FB_ENCODER) ? MFCD_HOME_MARKER :
      (e.pri_type == MFCD_FB_RESOLVER) ? MFCD_HOME_NULL : MFCD_HOME_NONE;
    e.step_hi_pct = 7'h46;
    e.step_lo_pct = 7'h23;
    return e;
  endfunction : ex
  task automatic chk(input string nm, input logic [41:0] e, input logic [41:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // zero wait states expected, but the wait stays open-ended up to a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (n == 16) err_count++;
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : apb
  task automatic acc_p(input logic w, input logic [1:0] x, input logic [4:0] i,
      input logic [31:0] v);
    apb(1'b1, `MFCD_OFF_AXIS_SEL, {30'h0, x});
    apb(1'b1, `MFCD_OFF_PARAM_IDX, {27'h0, i});
    apb(w, `MFCD_OFF_PARAM_DATA, v);
  endtask : acc_p
  task automatic reinit();
    apb(1'b1, `MFCD_OFF_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
  endtask : reinit
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    conclude();
  end
  // ------
  // tests
  // ------
  initial begin
    req = '0;
    presetn = 1'b0;
    bad = 4'h0;
    seed = 32'h50;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      acc_p(1'b0, 2'h2, di[i], 32'h0);
      chk("default", 42'(dv[i]), 42'(rd));
    end
    for (int a = 0; a < 4; a++) chk("reset cfg", ex(6'(a + 1), 1'b0, 3'h3, 2'h0), cfg[a]);
    $display("test defaults done");
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 42'h1, 42'(er));
    acc_p(1'b0, 2'h0, 5'h14, 32'h0);
    chk("index", 42'h1, 42'(er));
    acc_p(1'b1, 2'h0, `MFCD_P_STEP_HI, 32'h78);
    acc_p(1'b0, 2'h0, `MFCD_P_STEP_HI, 32'h0);
    chk("hi pct", 42'h64, 42'(rd));
    acc_p(1'b1, 2'h0, `MFCD_P_STEP_HI, 32'h46);
    acc_p(1'b1, 2'h0, `MFCD_P_PRI_CHAN, 32'h9);
    acc_p(1'b1, 2'h0, `MFCD_P_PRI_SETUP, 32'h2);
    chk("staged", ex(6'h1, 1'b0, 3'h3, 2'h0), cfg[0]);
    reinit();
    chk("resolver", ex(6'h9, 1'b0, 3'h2, 2'h0), cfg[0]);
    apb(1'b0, `MFCD_OFF_DECODE, 32'h0);
    chk("decode", 42'(32'(ex(6'h9, 1'b0, 3'h2, 2'h0))), 42'(rd));
    $display("test staging done");
    for (int k = 0; k < 27; k++) begin
      rn = xs();
      ch = 6'(k);
      dr = rn[1:0];
      su = (ch inside {[9:16]}) ? 3'h1 + 3'(rn[31:8] % 5) : (ch < 6'h9) ? 3'h0 : 3'(rn[31:8] % 6);
      acc_p(1'b1, 2'h0, `MFCD_P_PRI_CHAN, 32'(ch));
      acc_p(1'b1, 2'h0, `MFCD_P_PRI_SETUP, 32'(su));
      acc_p(1'b1, 2'h0, `MFCD_P_DRIVE, 32'(dr));
      acc_p(1'b1, 2'h0, `MFCD_P_SEC_CHAN, rn[2] ? 32'h3 : 32'h0);
      apb(1'b1, `MFCD_OFF_IRQ_CLEAR, 32'h7);
      reinit();
      if (ch < 6'h19) chk("cfg", ex(ch, rn[2], su, dr), cfg[0]);
      else chk("type", 42'h7, 42'(cfg[0].pri_type));
      apb(1'b0, `MFCD_OFF_IRQ_STATUS, 32'h0);
      chk("cfg err", 42'(ch > 6'h18 || (ch == 6'h0 && !dr[1])), 42'(rd[0]));
      chk("init done", 42'h1, 42'(rd[2]));
    end
    $display("test codes done");
    apb(1'b1, `MFCD_OFF_IRQ_ENABLE, 32'h1);
    acc_p(1'b1, 2'h0, `MFCD_P_PRI_CHAN, 32'h1E);
    apb(1'b1, `MFCD_OFF_IRQ_CLEAR, 32'h7);
    chk("irq idle", 42'h0, 42'(irq));
    reinit();
    chk("irq on", 42'h1, 42'(irq));
    apb(1'b1, `MFCD_OFF_IRQ_ENABLE, 32'h0);
    chk("irq masked", 42'h0, 42'(irq));
    apb(1'b1, `MFCD_OFF_IRQ_CLEAR, 32'h7);
    apb(1'b0, `MFCD_OFF_IRQ_STATUS, 32'h0);
    chk("cleared", 42'h0, 42'(rd));
    $display("test irq done");
    acc_p(1'b1, 2'h0, `MFCD_P_PRI_CHAN, 32'h1);
    acc_p(1'b1, 2'h0, `MFCD_P_SEC_CHAN, 32'h0);
    acc_p(1'b1, 2'h0, `MFCD_P_SEC_SETUP, 32'h7);
    reinit();
    apb(1'b0, `MFCD_OFF_AXIS_STATUS, 32'h0);
    chk("single loop", 42'h0, 42'(rd[0]));
    acc_p(1'b1, 2'h0, `MFCD_P_SEC_CHAN, 32'h3);
    reinit();
    chk("dual flag", 42'h1, 42'(cfg[0].dual_loop));
    apb(1'b0, `MFCD_OFF_AXIS_STATUS, 32'h0);
    chk("dual loop", 42'h1, 42'(rd[0]));
    $display("test loop mode done");
    bad <= 4'h2;
    repeat (4) @(posedge pclk);
    apb(1'b0, `MFCD_OFF_IRQ_STATUS, 32'h0);
    chk("brush hall", 42'h0, 42'(rd[1]));
    acc_p(1'b1, 2'h1, `MFCD_P_DRIVE, 32'h1);
    apb(1'b1, `MFCD_OFF_IRQ_ENABLE, 32'h2);
    reinit();
    repeat (2) @(posedge pclk);
    chk("hall irq", 42'h1, 42'(irq));
    apb(1'b0, `MFCD_OFF_AXIS_STATUS, 32'h0);
    chk("hall flt", 42'h2, 42'(rd[7:4]));
    $display("test hall done");
    conclude();
  end
endmodule : tb_top
